// file: bench/tb.sv
// Self-checking bench for the auto-baud and wake block
`timescale 1ns/1ns
`include "uab_map.svh"
module tb;
  import uab_pkg::*;
  typedef struct {
    logic [7:0]  a;
    logic        wr;
    logic [31:0] d;
    logic [31:0] exp;
  } uab_row_s;
  localparam int LIMIT = 95000;
  logic                   aclk = 1'h0, aresetn = 1'h0;
  logic [`UAB_ADDR_W-1:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0]            s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0]             s_axi_bresp, s_axi_rresp, resp;
  logic                   s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic                   s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic                   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic                   s_axi_rvalid, serial_rx_line, busy, irq;
  logic                   sleep_mode = 1'h0, receiver_idle_flag = 1'h1, rx_char_done = 1'h0;
  logic                   start = 1'h0, woke = 1'h0;
  logic                   receive_irq_flag, receiver_hold_idle, receive_data_read, wake_request;
  logic [15:0]            frame = 16'h0, bit_cycles = 16'h10;
  logic [4:0]             nbits = 5'hA;
  uab_divisor_t           baud_divisor;
  int                     miscompares = 0, samples_checked = 0, cyc = 0;
  uab_row_s rows [11] = '{
    '{`UAB_OFS_BAUD_CTRL, 1'h0, 32'h0, 32'h40}, '{`UAB_OFS_DIVISOR, 1'h0, 32'h0, 32'h0},
    '{`UAB_OFS_IRQ_STATUS, 1'h0, 32'h0, 32'h0}, '{`UAB_OFS_IRQ_MASK, 1'h0, 32'h0, 32'h0},
    '{`UAB_OFS_RX_FLAG, 1'h0, 32'h0, 32'h0},
    '{`UAB_OFS_DIVISOR, 1'h1, 32'hFFFFABCD, 32'hABCD},
    '{`UAB_OFS_IRQ_MASK, 1'h1, 32'hFFFFFFFF, 32'h7},
    '{`UAB_OFS_IRQ_MASK, 1'h1, 32'h0, 32'h0},
    '{`UAB_OFS_BAUD_CTRL, 1'h1, 32'h100, 32'h140},
    '{`UAB_OFS_BAUD_CTRL, 1'h1, 32'h103, 32'h143},
    '{`UAB_OFS_BAUD_CTRL, 1'h1, 32'h0, 32'h40}};

  uab_top #(.ABD_PRESCALE(1)) uab_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .serial_rx_line, .sleep_mode, .receiver_idle_flag, .rx_char_done, .rx_char_data(8'hA5),
    .baud_divisor, .receive_irq_flag, .receiver_hold_idle, .receive_data_read,
    .wake_request, .irq);
  uab_rx_sender uab_rx_sender_inst (.aclk(aclk), .start(start), .frame(frame),
    .nbits(nbits), .bit_cycles(bit_cycles), .line(serial_rx_line), .busy(busy));

  always #50 aclk = ~aclk;

  task automatic tally_and_finish();
    if (miscompares == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (wake_request) woke <= 1'h1;
    if (cyc == LIMIT) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw = 1'h0, w = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin
        aw = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w && s_axi_wready) begin
        w = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    r = s_axi_bresp;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, resp);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, rd, resp);
    check(rd, exp);
  endtask

  task automatic send(input logic [15:0] f, input logic [4:0] n, input logic [15:0] b);
    frame <= f;
    nbits <= n;
    bit_cycles <= b;
    start <= 1'h1;
    @(posedge aclk);
    start <= 1'h0;
    do @(posedge aclk); while (busy);
    repeat (8) @(posedge aclk);
  endtask

  task automatic pulse_char();
    rx_char_done <= 1'h1;
    @(posedge aclk);
    rx_char_done <= 1'h0;
    @(posedge aclk);
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      axi_rd(rows[i].a, rd, resp);
      check(rd, rows[i].exp);
    end
    wr(`UAB_OFS_IRQ_MASK, 32'h7);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    check({s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid, irq,
           receive_irq_flag, receiver_hold_idle, receive_data_read, wake_request,
           baud_divisor}, 32'h03800000);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd_chk(`UAB_OFS_IRQ_MASK, 32'h0);
    axi_wr(8'h40, 32'h1, resp);
    check(32'(resp), 32'h2);
    axi_rd(8'h40, rd, resp);
    check(32'(resp), 32'h2);
    pulse_char();
    check(32'(receive_irq_flag), 32'h1);
    rd_chk(`UAB_OFS_RX_DATA, 32'hA5);
    rd_chk(`UAB_OFS_RX_FLAG, 32'h0);
    // Auto-baud, 0x55 at 16 cycles a bit: 128 ticks
    wr(`UAB_OFS_BAUD_CTRL, 32'h1);
    send(16'h02AA, 5'hA, 16'h10);
    rd_chk(`UAB_OFS_BAUD_CTRL, 32'h40);
    rd_chk(`UAB_OFS_RX_FLAG, 32'h1);
    rd_chk(`UAB_OFS_IRQ_STATUS, 32'h1);
    check(32'(baud_divisor - 16'h007F < 16'h3), 32'h1);
    wr(`UAB_OFS_IRQ_MASK, 32'h1);
    rd_chk(`UAB_OFS_IRQ_MASK, 32'h1);
    check(32'(irq), 32'h1);
    wr(`UAB_OFS_IRQ_STATUS, 32'h1);
    rd_chk(`UAB_OFS_IRQ_STATUS, 32'h0);
    check(32'(irq), 32'h0);
    rd_chk(`UAB_OFS_RX_DATA, 32'hA5);
    rd_chk(`UAB_OFS_RX_FLAG, 32'h0);
    // Overflow: 66400 ticks wrap to 864
    wr(`UAB_OFS_BAUD_CTRL, 32'h1);
    fork
      send(16'h02AA, 5'hA, 16'h206C);
      begin
        do axi_rd(`UAB_OFS_IRQ_STATUS, rd, resp); while (rd[2] !== 1'h1);
        wr(`UAB_OFS_BAUD_CTRL, 32'h1);
        rd_chk(`UAB_OFS_BAUD_CTRL, 32'hC1);
      end
    join
    rd_chk(`UAB_OFS_BAUD_CTRL, 32'hC0);
    rd_chk(`UAB_OFS_IRQ_STATUS, 32'h5);
    check(32'(baud_divisor - 16'h035F < 16'h3), 32'h1);
    wr(`UAB_OFS_BAUD_CTRL, 32'h0);
    rd_chk(`UAB_OFS_BAUD_CTRL, 32'h40);
    wr(`UAB_OFS_IRQ_STATUS, 32'h7);
    rd_chk(`UAB_OFS_RX_DATA, 32'hA5);
    // Wake on a break while asleep
    rd_chk(`UAB_OFS_BAUD_CTRL, 32'h40);
    wr(`UAB_OFS_BAUD_CTRL, 32'h2);
    pulse_char();
    sleep_mode <= 1'h1;
    check(32'({receive_irq_flag, receiver_hold_idle}), 32'h1);
    send(16'h2000, 5'hE, 16'h10);
    check(32'({woke, receive_irq_flag, receiver_hold_idle}), 32'h6);
    sleep_mode <= 1'h0;
    rd_chk(`UAB_OFS_BAUD_CTRL, 32'h40);
    rd_chk(`UAB_OFS_IRQ_STATUS, 32'h2);
    rd_chk(`UAB_OFS_RX_DATA, 32'hA5);
    rd_chk(`UAB_OFS_RX_FLAG, 32'h0);
    // Non-zero character while armed: first low stretch wakes
    wr(`UAB_OFS_IRQ_STATUS, 32'h7);
    wr(`UAB_OFS_BAUD_CTRL, 32'h2);
    send(16'h0202, 5'hA, 16'h10);
    rd_chk(`UAB_OFS_RX_FLAG, 32'h1);
    rd_chk(`UAB_OFS_BAUD_CTRL, 32'h40);
    receiver_idle_flag <= 1'h0;
    rd_chk(`UAB_OFS_BAUD_CTRL, 32'h0);
    tally_and_finish();
  end
endmodule

// file: bench/uab_monitor.sv
// Port-level checker for the auto-baud and wake block
`timescale 1ns/1ns
`include "uab_map.svh"
module uab_monitor #(
  parameter int ABD_PRESCALE = `UAB_ABD_PRESCALE
) (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic [`UAB_ADDR_W-1:0] s_axi_araddr,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wready,
  input wire logic                   serial_rx_line,
  input wire logic                   sleep_mode,
  input wire logic                   rx_char_done,
  input wire uab_pkg::uab_divisor_t  baud_divisor,
  input wire logic                   receive_irq_flag,
  input wire logic                   receiver_hold_idle,
  input wire logic                   receive_data_read,
  input wire logic                   wake_request
);
  import uab_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_read_clears_flag: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `UAB_OFS_RX_DATA && !rx_char_done
    && serial_rx_line |=> receive_data_read && !receive_irq_flag)
    else $error("read kept flag");
  a_hold_blocks_char: assert property (
    receiver_hold_idle && rx_char_done && !receive_irq_flag && serial_rx_line
    |=> !receive_irq_flag)
    else $error("char taken in hold");
  a_char_sets_flag: assert property (
    !receiver_hold_idle && rx_char_done |=> receive_irq_flag)
    else $error("char missed flag");
  a_fall_wakes: assert property (
    receiver_hold_idle && !receive_irq_flag && $fell(serial_rx_line)
    |=> !receive_irq_flag ##[1:5] receive_irq_flag)
    else $error("wake edge missed");
  a_sleep_wake_req: assert property (
    receiver_hold_idle && sleep_mode && $fell(serial_rx_line) |-> ##[2:7] wake_request)
    else $error("no wake request");
  a_rise_ends_wake: assert property (
    receiver_hold_idle && $rose(serial_rx_line) |-> ##[2:7] !receiver_hold_idle)
    else $error("wake not ended");
  a_sleep_divisor: assert property (
    sleep_mode && s_axi_awready && s_axi_wready |=> $stable(baud_divisor))
    else $error("divisor moved in sleep");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_read_retire: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read not retired");
endmodule

bind uab_top uab_monitor #(.ABD_PRESCALE(ABD_PRESCALE)) uab_monitor_inst (
  .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_awready, .s_axi_wready, .serial_rx_line, .sleep_mode,
  .rx_char_done, .baud_divisor, .receive_irq_flag, .receiver_hold_idle,
  .receive_data_read, .wake_request
);

// file: bench/uab_rx_sender.sv
// Remote serial sender: shifts a frame out LSB first, line idles high
`timescale 1ns/1ns
module uab_rx_sender (
  input  wire logic        aclk,
  input  wire logic        start,
  input  wire logic [15:0] frame,
  input  wire logic [4:0]  nbits,
  input  wire logic [15:0] bit_cycles,
  output logic             line,
  output logic             busy
);
  logic [15:0] shift_r = 16'h0;
  logic [4:0]  left_r = 5'h0;
  logic [15:0] cnt_r = 16'h0;
  initial line = 1'h1;
  initial busy = 1'h0;
  always @(posedge aclk) begin
    if (start && !busy) begin
      line <= frame[0];
      shift_r <= frame >> 1;
      left_r <= nbits - 5'h1;
      cnt_r <= bit_cycles - 16'h1;
      busy <= 1'h1;
    end else if (busy) begin
      if (cnt_r != 16'h0) cnt_r <= cnt_r - 16'h1;
      else if (left_r == 5'h0) begin
        busy <= 1'h0;
        line <= 1'h1;
      end else begin
        line <= shift_r[0];
        shift_r <= shift_r >> 1;
        left_r <= left_r - 5'h1;
        cnt_r <= bit_cycles - 16'h1;
      end
    end
  end
endmodule

// file: core/uab_baud_counter.sv
// Prescaled 16-bit measurement counter that keeps running past overflow
`timescale 1ns/1ns
module uab_baud_counter #(
  parameter int PRESCALE = 8,
  parameter int WIDTH    = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clear,
  input  wire logic             run,
  output logic      [WIDTH-1:0] count,
  output logic                  overflow
);
  localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

  logic [PW-1:0]    pre_r;
  logic [WIDTH-1:0] cnt_r;
  logic             tick;

  assign tick = run && (pre_r == PRE_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      pre_r <= '0;
    end else if (run) begin
      pre_r <= tick ? '0 : pre_r + 1'b1;
    end
  end

  // Wraps and keeps counting after the top value
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      cnt_r <= '0;
    end else if (tick) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign count    = cnt_r;
  assign overflow = tick && (&cnt_r);
endmodule

// file: core/uab_map.svh
// Offsets, fields, reset values and counts of the auto-baud block
`ifndef UAB_MAP_SVH
`define UAB_MAP_SVH

`define UAB_ADDR_W          8
`define UAB_OFS_BAUD_CTRL   8'h00
`define UAB_OFS_DIVISOR     8'h04
`define UAB_OFS_RX_DATA     8'h08
`define UAB_OFS_IRQ_STATUS  8'h0C
`define UAB_OFS_IRQ_MASK    8'h10
`define UAB_OFS_RX_FLAG     8'h14

`define UAB_BIT_AUTOBAUD_ENABLE       0
`define UAB_BIT_WUE         1
`define UAB_BIT_RCIDLE      6
`define UAB_BIT_AUTOBAUD_OVERFLOW_FLAG      7
`define UAB_BIT_SYNC_MODE   8

`define UAB_IRQ_ABD_DONE    0
`define UAB_IRQ_WAKE        1
`define UAB_IRQ_OVERFLOW    2
`define UAB_IRQ_W           3

`define UAB_RST_DIVISOR     16'h0000
`define UAB_RST_MASK        3'h0
`define UAB_ABD_RISE_LAST   3'h5
`define UAB_ABD_PRESCALE    8

`define UAB_RESP_OKAY       2'h0
`define UAB_RESP_SLVERR     2'h2

`endif

// file: core/uab_pkg.sv
// Types shared by the auto-baud and wake block
package uab_pkg;

  typedef enum logic [1:0] {
    ABD_IDLE,
    ABD_WAIT_FIRST,
    ABD_MEASURE
  } uab_abd_state_e;

  typedef enum logic [1:0] {
    WK_OFF,
    WK_WAIT_FALL,
    WK_WAIT_RISE
  } uab_wake_state_e;

  typedef logic [15:0] uab_divisor_t;

endpackage

// file: core/uab_sync.sv
// Two-stage synchroniser for the receive pin with edge detection behind it
`timescale 1ns/1ns
module uab_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  // Line idles high, so all stages reset high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      last_r <= 1'b1;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise  = sync_r & ~last_r;
  assign fall  = ~sync_r & last_r;
endmodule

// file: core/uab_top.sv
// Auto-baud overflow handling and wake-on-break receive logic with AXI4-Lite registers
// Overview of operation
// [R01] Overflow flag sets if the count passes 16 bits before fifth rise.
// [R02] After overflow the counter runs on until the fifth rise.
// [R03] Fifth rise sets receive flag and clears auto-baud enable.
// [R04] Receive data read clears the auto-baud receive flag.
// [R05] Software clears the overflow flag by a direct write.
// [R06] Abort: clear enable, then overflow; overflow holds while enable set.
// [R07] In sleep the baud measurement stops.
// [R08] Wake-on-activity works only in asynchronous mode.
// [R09] Wake enable holds the receiver idle, watching the line.
// [R10] A falling receive-line edge is the wake event.
// [R11] The wake event raises the receive flag, awake or asleep.
// [R12] The rise ending the break clears wake enable.
// [R13] Sender's wake character is all zero, ten bit times or more.
// [R14] A non-zero character's first low stretch is the wake event.
// [R15] Receive data read clears the wake receive flag.
// [R16] Software checks receiver idle before setting wake enable.
// [R17] Sender leaves break and idle time for oscillator start-up.
// [R18] Receive line is synchronised before edge detection.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "uab_map.svh"
module uab_top #(
  parameter int ABD_PRESCALE = `UAB_ABD_PRESCALE
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [`UAB_ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic      [1:0]                  s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [`UAB_ADDR_W-1:0]      s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic      [31:0]                 s_axi_rdata,
  output logic      [1:0]                  s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        serial_rx_line,
  input  wire logic                        sleep_mode,
  input  wire logic                        receiver_idle_flag,
  input  wire logic                        rx_char_done,
  input  wire logic [7:0]                  rx_char_data,
  output uab_pkg::uab_divisor_t            baud_divisor,
  output logic                             receive_irq_flag,
  output logic                             receiver_hold_idle,
  output logic                             receive_data_read,
  output logic                             wake_request,
  output logic                             irq
);
  import uab_pkg::*;

  logic                  rx_level;
  logic                  rx_rise;
  logic                  rx_fall;
  logic [15:0]           abd_count;
  logic                  abd_ovf_tick;
  logic                  abd_clear;
  logic                  abd_run;
  uab_abd_state_e        abd_state_r;
  logic [2:0]            rise_cnt_r;
  logic                  abd_done;
  uab_wake_state_e       wk_state_r;
  logic                  wake_event;
  logic                  wake_end;

  logic                  autobaud_enable_r;
  logic                  wake_on_break_enable_r;
  logic                  autobaud_overflow_flag_r;
  logic                  sync_mode_r;
  uab_divisor_t          divisor_r;
  logic [`UAB_IRQ_W-1:0] irq_status_r;
  logic [`UAB_IRQ_W-1:0] irq_mask_r;
  logic                  rx_flag_r;
  logic                  rx_read_r;
  logic                  hold_idle_r;
  logic                  wake_req_r;
  logic                  irq_r;

  logic                  aw_held_r;
  logic                  w_held_r;
  logic [`UAB_ADDR_W-1:0] waddr_r;
  logic [31:0]           wdata_r;
  logic [3:0]            wstrb_r;
  logic                  bvalid_r;
  logic [1:0]            bresp_r;
  logic                  rvalid_r;
  logic [31:0]           rdata_r;
  logic [1:0]            rresp_r;
  logic                  wr_fire;
  logic                  rd_fire;
  logic                  wr_ctrl;
  logic                  wr_mapped;
  logic                  rd_mapped;
  logic [31:0]           rd_value;
  logic [`UAB_IRQ_W-1:0] irq_events;

  uab_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (serial_rx_line),
    .level   (rx_level),
    .rise    (rx_rise),
    .fall    (rx_fall)
  ); // R18

  uab_baud_counter #(
    .PRESCALE (ABD_PRESCALE),
    .WIDTH    (16)
  ) u_cnt (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clear    (abd_clear),
    .run      (abd_run),
    .count    (abd_count),
    .overflow (abd_ovf_tick)
  );

  // Auto-baud measurement: first rise starts, fifth rise ends
  assign abd_clear = (abd_state_r == ABD_WAIT_FIRST) && rx_rise;
  assign abd_run   = (abd_state_r == ABD_MEASURE) && !sleep_mode; // R02 R07
  assign abd_done  = (abd_state_r == ABD_MEASURE) && rx_rise
                     && (rise_cnt_r == `UAB_ABD_RISE_LAST - 3'h1); // R03

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      abd_state_r <= ABD_IDLE;
      rise_cnt_r  <= 3'h0;
    end else begin
      case (abd_state_r)
        ABD_IDLE: begin
          if (autobaud_enable_r && !sync_mode_r) begin
            abd_state_r <= ABD_WAIT_FIRST;
          end
        end
        ABD_WAIT_FIRST: begin
          if (!autobaud_enable_r) begin
            abd_state_r <= ABD_IDLE;
          end else if (rx_rise) begin
            abd_state_r <= ABD_MEASURE;
            rise_cnt_r  <= 3'h1;
          end
        end
        ABD_MEASURE: begin
          if (!autobaud_enable_r || abd_done) begin
            abd_state_r <= ABD_IDLE;
          end else if (rx_rise) begin
            rise_cnt_r <= rise_cnt_r + 3'h1;
          end
        end
        default: abd_state_r <= ABD_IDLE;
      endcase
    end
  end

  // Wake-on-break: armed only in asynchronous mode
  assign wake_event = (wk_state_r == WK_WAIT_FALL) && rx_fall; // R10 R14
  assign wake_end   = (wk_state_r == WK_WAIT_RISE) && rx_rise; // R12

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wk_state_r <= WK_OFF;
    end else begin
      case (wk_state_r)
        WK_OFF: begin
          if (wake_on_break_enable_r && !sync_mode_r) begin
            wk_state_r <= rx_level ? WK_WAIT_FALL : WK_WAIT_RISE; // R08
          end
        end
        WK_WAIT_FALL: begin
          if (!wake_on_break_enable_r || sync_mode_r) begin
            wk_state_r <= WK_OFF;
          end else if (rx_fall) begin
            wk_state_r <= WK_WAIT_RISE;
          end
        end
        WK_WAIT_RISE: begin
          if (!wake_on_break_enable_r || sync_mode_r || rx_rise) begin
            wk_state_r <= WK_OFF;
          end
        end
        default: wk_state_r <= WK_OFF;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_idle_r <= 1'b0;
      wake_req_r  <= 1'b0;
    end else begin
      hold_idle_r <= wake_on_break_enable_r && !sync_mode_r && !wake_end; // R09
      wake_req_r  <= wake_event && sleep_mode; // R11
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  assign wr_fire   = aw_held_r && w_held_r && !bvalid_r;
  assign wr_mapped = (waddr_r == `UAB_OFS_BAUD_CTRL) || (waddr_r == `UAB_OFS_DIVISOR)
                     || (waddr_r == `UAB_OFS_IRQ_STATUS) || (waddr_r == `UAB_OFS_IRQ_MASK);
  assign wr_ctrl   = wr_fire && (waddr_r == `UAB_OFS_BAUD_CTRL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      waddr_r   <= '0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `UAB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        waddr_r   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_mapped ? `UAB_RESP_OKAY : `UAB_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Control bits; hardware clears take priority over a simultaneous write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      autobaud_enable_r      <= 1'b0;
      wake_on_break_enable_r <= 1'b0;
      sync_mode_r            <= 1'b0;
    end else begin
      if (wr_ctrl && wstrb_r[0]) begin
        autobaud_enable_r      <= wdata_r[`UAB_BIT_AUTOBAUD_ENABLE];
        wake_on_break_enable_r <= wdata_r[`UAB_BIT_WUE];
      end
      if (wr_ctrl && wstrb_r[1]) begin
        sync_mode_r <= wdata_r[`UAB_BIT_SYNC_MODE];
      end
      if (abd_done) begin
        autobaud_enable_r <= 1'b0; // R03
      end
      if (wake_end) begin
        wake_on_break_enable_r <= 1'b0; // R12
      end
    end
  end

  // Overflow flag: set wins; clear only once enable is already off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      autobaud_overflow_flag_r <= 1'b0;
    end else if (abd_run && abd_ovf_tick) begin
      autobaud_overflow_flag_r <= 1'b1; // R01
    end else if (wr_ctrl && wstrb_r[0] && !wdata_r[`UAB_BIT_AUTOBAUD_OVERFLOW_FLAG]
                 && !autobaud_enable_r) begin
      autobaud_overflow_flag_r <= 1'b0; // R05 R06
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divisor_r <= `UAB_RST_DIVISOR;
    end else if (abd_done) begin
      divisor_r <= abd_count; // R03
    end else if (wr_fire && (waddr_r == `UAB_OFS_DIVISOR)) begin
      if (wstrb_r[0]) divisor_r[7:0] <= wdata_r[7:0];
      if (wstrb_r[1]) divisor_r[15:8] <= wdata_r[15:8];
    end
  end

  // Receive flag: set by events, cleared by a data read; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_flag_r <= 1'b0;
    end else if (abd_done || wake_event || (rx_char_done && !hold_idle_r)) begin
      rx_flag_r <= 1'b1; // R03 R11 R09
    end else if (rd_fire && (s_axi_araddr == `UAB_OFS_RX_DATA)) begin
      rx_flag_r <= 1'b0; // R04 R15
    end
  end

  // Interrupt status, write one to clear, set wins
  assign irq_events = {abd_run && abd_ovf_tick, wake_event, abd_done};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_r <= '0;
      irq_mask_r   <= `UAB_RST_MASK;
      irq_r        <= 1'b0;
    end else begin
      if (wr_fire && (waddr_r == `UAB_OFS_IRQ_STATUS) && wstrb_r[0]) begin
        irq_status_r <= (irq_status_r & ~wdata_r[`UAB_IRQ_W-1:0]) | irq_events;
      end else begin
        irq_status_r <= irq_status_r | irq_events;
      end
      if (wr_fire && (waddr_r == `UAB_OFS_IRQ_MASK) && wstrb_r[0]) begin
        irq_mask_r <= wdata_r[`UAB_IRQ_W-1:0];
      end
      irq_r <= |(irq_status_r & irq_mask_r);
    end
  end

  // AXI4-Lite read path: one read at a time, answer one cycle after acceptance
  assign rd_fire   = s_axi_arvalid && !rvalid_r;
  assign rd_mapped = (s_axi_araddr == `UAB_OFS_BAUD_CTRL) || (s_axi_araddr == `UAB_OFS_DIVISOR)
                     || (s_axi_araddr == `UAB_OFS_RX_DATA) || (s_axi_araddr == `UAB_OFS_IRQ_STATUS)
                     || (s_axi_araddr == `UAB_OFS_IRQ_MASK) || (s_axi_araddr == `UAB_OFS_RX_FLAG);

  always_comb begin
    rd_value = 32'h0000_0000;
    case (s_axi_araddr)
      `UAB_OFS_BAUD_CTRL: begin
        rd_value[`UAB_BIT_AUTOBAUD_ENABLE]     = autobaud_enable_r;
        rd_value[`UAB_BIT_WUE]       = wake_on_break_enable_r;
        rd_value[`UAB_BIT_RCIDLE]    = receiver_idle_flag;
        rd_value[`UAB_BIT_AUTOBAUD_OVERFLOW_FLAG]    = autobaud_overflow_flag_r;
        rd_value[`UAB_BIT_SYNC_MODE] = sync_mode_r;
      end
      `UAB_OFS_DIVISOR:    rd_value[15:0] = divisor_r;
      `UAB_OFS_RX_DATA:    rd_value[7:0] = rx_char_data;
      `UAB_OFS_IRQ_STATUS: rd_value[`UAB_IRQ_W-1:0] = irq_status_r;
      `UAB_OFS_IRQ_MASK:   rd_value[`UAB_IRQ_W-1:0] = irq_mask_r;
      `UAB_OFS_RX_FLAG:    rd_value[0] = rx_flag_r;
      default:             rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `UAB_RESP_OKAY;
      rx_read_r <= 1'b0;
    end else begin
      rx_read_r <= rd_fire && (s_axi_araddr == `UAB_OFS_RX_DATA);
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_value;
        rresp_r  <= rd_mapped ? `UAB_RESP_OKAY : `UAB_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready      = !aw_held_r;
  assign s_axi_wready       = !w_held_r;
  assign s_axi_bvalid       = bvalid_r;
  assign s_axi_bresp        = bresp_r;
  assign s_axi_arready      = !rvalid_r;
  assign s_axi_rvalid       = rvalid_r;
  assign s_axi_rdata        = rdata_r;
  assign s_axi_rresp        = rresp_r;
  assign baud_divisor       = divisor_r;
  assign receive_irq_flag   = rx_flag_r;
  assign receiver_hold_idle = hold_idle_r;
  assign receive_data_read  = rx_read_r;
  assign wake_request       = wake_req_r;
  assign irq                = irq_r;
endmodule
